// ==== shared/pmc_pkg.sv ====
// Package of offsets, widths and timing constants for the performance monitor counters.
package pmc_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the parallel register port.
	// ----------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam logic [8:0] OFS_FRAMING_LO = 9'h050;
	localparam logic [8:0] OFS_FRAMING_HI = 9'h051;
	localparam logic [8:0] OFS_CRC_LO = 9'h052;
	localparam logic [8:0] OFS_CRC_HI = 9'h053;
	localparam logic [8:0] OFS_LINE_LO = 9'h054;
	localparam logic [8:0] OFS_LINE_HI = 9'h055;
	localparam logic [8:0] OFS_REMOTE_LO = 9'h056;
	localparam logic [8:0] OFS_REMOTE_HI = 9'h057;
	localparam logic [8:0] OFS_PATTERN_LO = 9'h058;
	localparam logic [8:0] OFS_PATTERN_HI = 9'h059;
	localparam logic [8:0] OFS_ALARM = 9'h05a;
	localparam logic [8:0] OFS_SPARE4 = 9'h05b;
	localparam logic [8:0] OFS_SPARE5 = 9'h05c;

	// ----------------------------------------------------------------
	// Counter widths and the alarm byte layout.
	// ----------------------------------------------------------------
	localparam int FRAMING_W = 12;
	localparam int CRC_W = 10;
	localparam int LINE_W = 16;
	localparam int REMOTE_W = 10;
	localparam int PATTERN_W = 12;
	localparam int FRAME_LOSS_W = 4;
	localparam int ALIGN_W = 2;
	localparam int SEF_W = 2;
	localparam int FRAME_LOSS_LSB = 4;
	localparam int ALIGN_LSB = 2;
	localparam int SEF_LSB = 0;

	// ----------------------------------------------------------------
	// Bit positions in the overflow enable and overflow pulse vectors.
	// ----------------------------------------------------------------
	localparam int NUM_CNT = 8;
	localparam int IDX_FRAMING = 0;
	localparam int IDX_CRC = 1;
	localparam int IDX_LINE = 2;
	localparam int IDX_REMOTE = 3;
	localparam int IDX_PATTERN = 4;
	localparam int IDX_FRAME_LOSS = 5;
	localparam int IDX_ALIGN = 6;
	localparam int IDX_SEF = 7;

	// ----------------------------------------------------------------
	// Spare-bit capture and reset values.
	// ----------------------------------------------------------------
	localparam int SA_LANES = 5;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int CLK_FREQ_KHZ = 25000;
	localparam int SA_HOLD_TIME_US = 2000;
	localparam int SA_HOLD_CYCLES = SA_HOLD_TIME_US * CLK_FREQ_KHZ / 1000;

endpackage : pmc_pkg

// ==== core/pmc_counter.sv ====
// Event counter with wrap or saturate, clear and one-second snapshot.
`timescale 1ns/1ps
module pmc_counter #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Control.
	input wire logic inc,
	input wire logic clr,
	input wire logic snap,
	input wire logic wrap_en,
	// Results.
	output logic [W-1:0] count,
	output logic [W-1:0] held,
	output logic ovf
);
	logic [W-1:0] count_q, count_d, held_q, held_d, base;
	logic ovf_q, ovf_d;

	// ----------------------------------------------------------------
	// Next count.
	// ----------------------------------------------------------------
	// A clear or snapshot restarts from zero, but an event in the same
	// cycle still lands in the fresh count so nothing is lost.
	always_comb begin
		base = (clr || snap) ? '0 : count_q;
		held_d = snap ? count_q : held_q;
		count_d = base;
		ovf_d = 1'b0;
		if (inc) begin
			if (&base) begin
				count_d = wrap_en ? '0 : base;
				ovf_d = 1'b1;
			end else begin
				count_d = base + 1'b1;
			end
		end
	end

	// Register the count, the snapshot and the overflow pulse.
	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= '0;
			held_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			count_q <= count_d;
			held_q <= held_d;
			ovf_q <= ovf_d;
		end
	end

	assign count = count_q;
	assign held = held_q;
	assign ovf = ovf_q;
endmodule : pmc_counter

// ==== core/pmc_sa_capture.sv ====
// Double-buffered capture of receive spare bits from odd frames.
`timescale 1ns/1ps
module pmc_sa_capture #(
	parameter int HOLD_CYCLES = pmc_pkg::SA_HOLD_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Receive frame side.
	input wire logic odd_frame_strobe,
	input wire logic [3:0] frame_number,
	input wire logic [pmc_pkg::SA_LANES-1:0] sa_bits,
	input wire logic receive_multiframe_irq,
	// Committed buffers, lane 0 is Sa4.
	output logic [pmc_pkg::SA_LANES*8-1:0] sa_bytes
);
	import pmc_pkg::*;
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	logic [7:0] shadow_q [SA_LANES];
	logic [7:0] shadow_d [SA_LANES];
	logic [7:0] buf_q [SA_LANES];
	logic [7:0] buf_d [SA_LANES];
	logic [HW-1:0] hold_q, hold_d;
	logic commit;

	// ----------------------------------------------------------------
	// Shadow fill and commit.
	// ----------------------------------------------------------------
	// Frame 2n+1 lands in bit n. A multiframe mark that comes while the
	// hold window still runs is dropped so software keeps a stable byte.
	always_comb begin
		commit = receive_multiframe_irq && (hold_q == '0);
		hold_d = commit ? HW'(HOLD_CYCLES - 1) : (hold_q == '0 ? hold_q : hold_q - 1'b1);
		for (int i = 0; i < SA_LANES; i++) begin
			shadow_d[i] = shadow_q[i];
			if (odd_frame_strobe && frame_number[0]) begin
				shadow_d[i][frame_number[3:1]] = sa_bits[i];
			end
			buf_d[i] = commit ? shadow_d[i] : buf_q[i];
		end
	end

	// Register shadow, committed buffers and hold timer.
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_q <= '0;
			for (int i = 0; i < SA_LANES; i++) begin
				shadow_q[i] <= RST_BYTE;
				buf_q[i] <= RST_BYTE;
			end
		end else begin
			hold_q <= hold_d;
			for (int i = 0; i < SA_LANES; i++) begin
				shadow_q[i] <= shadow_d[i];
				buf_q[i] <= buf_d[i];
			end
		end
	end

	// Pack lanes for the register map.
	always_comb begin
		for (int i = 0; i < SA_LANES; i++) begin
			sa_bytes[i*8 +: 8] = buf_q[i];
		end
	end
endmodule : pmc_sa_capture

// ==== core/pmc_perf_monitor.sv ====
// Performance monitoring counters and spare-bit buffers of one framer.
`timescale 1ns/1ps
// Function
// - Overflow enabled: counter wraps to zero.
// - Overflow disabled: counter saturates at maximum.
// - 12-bit framing count, high read clears outside latch mode.
// - 10-bit CRC count, high read clears outside latch mode.
// - 16-bit line violation count, high read clears outside latch mode.
// - Count bipolar always, excess zeros optionally.
// - 10-bit remote block count, either read clears outside latch mode.
// - Pattern low read captures then clears count.
// - Pattern high read returns captured bits 11:8.
// - Pattern errors counted only while test runs.
// - Alarm byte packs three counts, read clears.
// - Frame-loss count increments per loss occurrence.
// - Alignment-change count increments per reframe pulse.
// - Severe frame count increments per occurrence.
// - Five spare buffers update together at multiframe.
// - Buffer bit n holds odd frame 2n+1.
// - Buffers hold unchanged two ms after update.
module pmc_perf_monitor #(
	parameter int SA_HOLD_CYCLES = pmc_pkg::SA_HOLD_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Parallel register port, read side.
	input wire logic reg_rd,
	input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	// Mode controls.
	input wire logic one_second_latch_enable,
	input wire logic one_second_tick,
	input wire logic count_excess_zeros_enable,
	input wire logic test_pattern_start,
	input wire logic [pmc_pkg::NUM_CNT-1:0] overflow_irq_enables,
	// Error and alarm events from the receive framer.
	input wire logic framing_bit_error,
	input wire logic crc_error,
	input wire logic bipolar_violation,
	input wire logic excess_zeros,
	input wire logic remote_block_error,
	input wire logic pattern_bit_error,
	input wire logic frame_loss_state,
	input wire logic alignment_change_pulse,
	input wire logic severely_errored_frame,
	// Spare-bit capture.
	input wire logic odd_frame_strobe,
	input wire logic [3:0] frame_number,
	input wire logic [pmc_pkg::SA_LANES-1:0] sa_bits,
	input wire logic receive_multiframe_irq,
	// Status toward the interrupt logic and other buffers.
	output logic [pmc_pkg::NUM_CNT-1:0] counter_overflow,
	output logic [23:0] spare_bit_upper_bytes
);
	import pmc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	logic latch_mode, snap;
	logic rd_frm_hi, rd_crc_hi, rd_line_hi, rd_rem, rd_pat_lo, rd_alarm;
	logic line_inc, pat_inc, loss_rise;
	logic [FRAMING_W-1:0] frm_cnt, frm_held;
	logic [CRC_W-1:0] crc_cnt, crc_held;
	logic [LINE_W-1:0] line_cnt, line_held;
	logic [REMOTE_W-1:0] rem_cnt, rem_held;
	logic [PATTERN_W-1:0] pat_cnt;
	logic [FRAME_LOSS_W-1:0] loss_cnt;
	logic [ALIGN_W-1:0] align_cnt;
	logic [SEF_W-1:0] sef_cnt;
	logic [SA_LANES*8-1:0] sa_bytes;
	logic [15:0] frm_view, crc_view, line_view, rem_view;
	logic [7:0] alarm_byte;
	logic [PATTERN_W-1:0] pat_cap_q, pat_cap_d;
	logic [7:0] hi_hold_q [4];
	logic [7:0] hi_hold_d [4];
	logic [7:0] rdata_q, rdata_d;
	logic ack_q, ack_d, loss_prev_q, loss_prev_d;

	// Picks the one-second snapshot or the live count for a read.
	function automatic logic [15:0] pick_view(input logic latched, input logic [15:0] live,
		input logic [15:0] held);
		pick_view = latched ? held : live;
	endfunction : pick_view

	// True when a read strobe addresses the given offset.
	function automatic logic hit(input logic rd, input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs);
		hit = rd && (addr == ofs);
	endfunction : hit

	// ----------------------------------------------------------------
	// Read decode and event qualification.
	// ----------------------------------------------------------------
	// In latch mode the framing, CRC, line and remote counts restart at each second boundary
	// instead of on reads, so the snapshot is a clean per-second figure.
	assign latch_mode = one_second_latch_enable;
	assign snap = one_second_tick && latch_mode;
	assign rd_frm_hi = hit(reg_rd, reg_addr, OFS_FRAMING_HI) && !latch_mode;
	assign rd_crc_hi = hit(reg_rd, reg_addr, OFS_CRC_HI) && !latch_mode;
	assign rd_line_hi = hit(reg_rd, reg_addr, OFS_LINE_HI) && !latch_mode;
	assign rd_rem = (hit(reg_rd, reg_addr, OFS_REMOTE_LO) ||
		hit(reg_rd, reg_addr, OFS_REMOTE_HI)) && !latch_mode;
	assign rd_pat_lo = hit(reg_rd, reg_addr, OFS_PATTERN_LO);
	assign rd_alarm = hit(reg_rd, reg_addr, OFS_ALARM);
	// A bipolar violation and an excess-zeros event in one cycle count once.
	assign line_inc = bipolar_violation || (excess_zeros && count_excess_zeros_enable);
	assign pat_inc = pattern_bit_error && test_pattern_start;
	assign loss_rise = frame_loss_state && !loss_prev_q;

	// ----------------------------------------------------------------
	// Latchable error counters.
	// ----------------------------------------------------------------
	pmc_counter #(.W(FRAMING_W)) u_frm (
		.clk(clk), .srst(srst), .inc(framing_bit_error), .clr(rd_frm_hi), .snap(snap),
		.wrap_en(overflow_irq_enables[IDX_FRAMING]), .count(frm_cnt), .held(frm_held),
		.ovf(counter_overflow[IDX_FRAMING])
	);
	pmc_counter #(.W(CRC_W)) u_crc (
		.clk(clk), .srst(srst), .inc(crc_error), .clr(rd_crc_hi), .snap(snap),
		.wrap_en(overflow_irq_enables[IDX_CRC]), .count(crc_cnt), .held(crc_held),
		.ovf(counter_overflow[IDX_CRC])
	);
	pmc_counter #(.W(LINE_W)) u_line (
		.clk(clk), .srst(srst), .inc(line_inc), .clr(rd_line_hi), .snap(snap),
		.wrap_en(overflow_irq_enables[IDX_LINE]), .count(line_cnt), .held(line_held),
		.ovf(counter_overflow[IDX_LINE])
	);
	pmc_counter #(.W(REMOTE_W)) u_rem (
		.clk(clk), .srst(srst), .inc(remote_block_error), .clr(rd_rem), .snap(snap),
		.wrap_en(overflow_irq_enables[IDX_REMOTE]), .count(rem_cnt), .held(rem_held),
		.ovf(counter_overflow[IDX_REMOTE])
	);

	// ----------------------------------------------------------------
	// Pattern error counter and alarm counters.
	// ----------------------------------------------------------------
	pmc_counter #(.W(PATTERN_W)) u_pat (
		.clk(clk), .srst(srst), .inc(pat_inc), .clr(rd_pat_lo), .snap(1'b0),
		.wrap_en(overflow_irq_enables[IDX_PATTERN]), .count(pat_cnt), .held(),
		.ovf(counter_overflow[IDX_PATTERN])
	);
	pmc_counter #(.W(FRAME_LOSS_W)) u_loss (
		.clk(clk), .srst(srst), .inc(loss_rise), .clr(rd_alarm), .snap(1'b0),
		.wrap_en(overflow_irq_enables[IDX_FRAME_LOSS]), .count(loss_cnt), .held(),
		.ovf(counter_overflow[IDX_FRAME_LOSS])
	);
	pmc_counter #(.W(ALIGN_W)) u_align (
		.clk(clk), .srst(srst), .inc(alignment_change_pulse), .clr(rd_alarm), .snap(1'b0),
		.wrap_en(overflow_irq_enables[IDX_ALIGN]), .count(align_cnt), .held(),
		.ovf(counter_overflow[IDX_ALIGN])
	);
	pmc_counter #(.W(SEF_W)) u_sef (
		.clk(clk), .srst(srst), .inc(severely_errored_frame), .clr(rd_alarm), .snap(1'b0),
		.wrap_en(overflow_irq_enables[IDX_SEF]), .count(sef_cnt), .held(),
		.ovf(counter_overflow[IDX_SEF])
	);

	// ----------------------------------------------------------------
	// Spare-bit buffers.
	// ----------------------------------------------------------------
	pmc_sa_capture #(.HOLD_CYCLES(SA_HOLD_CYCLES)) u_sa (
		.clk(clk),
		.srst(srst),
		.odd_frame_strobe(odd_frame_strobe),
		.frame_number(frame_number),
		.sa_bits(sa_bits),
		.receive_multiframe_irq(receive_multiframe_irq),
		.sa_bytes(sa_bytes)
	);
	assign spare_bit_upper_bytes = sa_bytes[SA_LANES*8-1:16];

	// ----------------------------------------------------------------
	// Read views.
	// ----------------------------------------------------------------
	assign frm_view = pick_view(latch_mode, 16'(frm_cnt), 16'(frm_held));
	assign crc_view = pick_view(latch_mode, 16'(crc_cnt), 16'(crc_held));
	assign line_view = pick_view(latch_mode, line_cnt, line_held);
	assign rem_view = pick_view(latch_mode, 16'(rem_cnt), 16'(rem_held));
	assign alarm_byte = {loss_cnt, align_cnt, sef_cnt};

	// ----------------------------------------------------------------
	// Read data, high-byte holds and edge memory.
	// ----------------------------------------------------------------
	// A low-byte read freezes the matching high byte, so the pair read in
	// the expected order is coherent even if events arrive in between.
	always_comb begin
		rdata_d = RST_BYTE;
		ack_d = reg_rd;
		pat_cap_d = pat_cap_q;
		loss_prev_d = frame_loss_state;
		for (int i = 0; i < 4; i++) begin
			hi_hold_d[i] = hi_hold_q[i];
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_FRAMING_LO: begin
					rdata_d = frm_view[7:0];
					hi_hold_d[0] = frm_view[15:8];
				end
				OFS_FRAMING_HI: rdata_d = hi_hold_q[0];
				OFS_CRC_LO: begin
					rdata_d = crc_view[7:0];
					hi_hold_d[1] = crc_view[15:8];
				end
				OFS_CRC_HI: rdata_d = hi_hold_q[1];
				OFS_LINE_LO: begin
					rdata_d = line_view[7:0];
					hi_hold_d[2] = line_view[15:8];
				end
				OFS_LINE_HI: rdata_d = hi_hold_q[2];
				OFS_REMOTE_LO: begin
					rdata_d = rem_view[7:0];
					hi_hold_d[3] = rem_view[15:8];
				end
				OFS_REMOTE_HI: rdata_d = hi_hold_q[3];
				OFS_PATTERN_LO: begin
					pat_cap_d = pat_cnt;
					rdata_d = pat_cnt[7:0];
				end
				OFS_PATTERN_HI: rdata_d = {4'h0, pat_cap_q[11:8]};
				OFS_ALARM: rdata_d = alarm_byte;
				OFS_SPARE4: rdata_d = sa_bytes[7:0];
				OFS_SPARE5: rdata_d = sa_bytes[15:8];
				default: rdata_d = RST_BYTE;
			endcase
		end
	end

	// Register the read port and the held bytes.
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= RST_BYTE;
			ack_q <= 1'b0;
			pat_cap_q <= '0;
			loss_prev_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				hi_hold_q[i] <= RST_BYTE;
			end
		end else begin
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			pat_cap_q <= pat_cap_d;
			loss_prev_q <= loss_prev_d;
			for (int i = 0; i < 4; i++) begin
				hi_hold_q[i] <= hi_hold_d[i];
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_ack = ack_q;
endmodule : pmc_perf_monitor

// ==== sim/pmc_perf_monitor_props.sv ====
// Checker of port relations of the performance monitor counters.
`timescale 1ns/1ps
module pmc_perf_monitor_props
	import pmc_pkg::*;
#(
	parameter int SA_HOLD_CYCLES = pmc_pkg::SA_HOLD_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire logic reg_rd,
	input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	// Controls and events.
	input wire logic one_second_latch_enable,
	input wire logic test_pattern_start,
	input wire logic framing_bit_error,
	input wire logic crc_error,
	input wire logic frame_loss_state,
	input wire logic alignment_change_pulse,
	input wire logic severely_errored_frame,
	input wire logic receive_multiframe_irq,
	// Results.
	input wire logic [pmc_pkg::NUM_CNT-1:0] counter_overflow,
	input wire logic [23:0] spare_bit_upper_bytes
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// --------------------------------------------------------
	// Register port answers.
	// --------------------------------------------------------
	// The hold windows assume SA_HOLD_CYCLES of at least 9; a shorter hold makes spare_hold_a fail.
	ack_latency_a: assert property (reg_rd |=> reg_ack)
		else $error("read not acknowledged");
	framing_hi_zero_a: assert property (reg_rd && reg_addr == OFS_FRAMING_HI |=>
		reg_rdata[7:4] == 4'h0) else $error("framing high byte upper bits set");
	pattern_hi_zero_a: assert property (reg_rd && reg_addr == OFS_PATTERN_HI |=>
		reg_rdata[7:4] == 4'h0) else $error("pattern high byte upper bits set");

	// --------------------------------------------------------
	// Clearing reads, checked with a quiet gap so no event can mask them.
	// --------------------------------------------------------
	framing_clear_a: assert property ((reg_rd && reg_addr == OFS_FRAMING_HI &&
		!one_second_latch_enable && !framing_bit_error) ##1 !framing_bit_error
		##1 (reg_rd && reg_addr == OFS_FRAMING_LO) |=> reg_rdata == 8'h00)
		else $error("framing count not cleared");
	pattern_idle_a: assert property ((reg_rd && reg_addr == OFS_PATTERN_LO &&
		!test_pattern_start) ##1 !test_pattern_start
		##1 (reg_rd && reg_addr == OFS_PATTERN_LO) |=> reg_rdata == 8'h00)
		else $error("pattern count moved while stopped");
	alarm_clear_a: assert property ((reg_rd && reg_addr == OFS_ALARM && !frame_loss_state
		&& !alignment_change_pulse && !severely_errored_frame)
		##1 (!frame_loss_state && !alignment_change_pulse && !severely_errored_frame)
		##1 (reg_rd && reg_addr == OFS_ALARM) |=> reg_rdata == 8'h00)
		else $error("alarm counts not cleared");

	// --------------------------------------------------------
	// Overflow and spare-bit buffers.
	// --------------------------------------------------------
	crc_ovf_cause_a: assert property (counter_overflow[IDX_CRC] |-> $past(crc_error))
		else $error("crc overflow without an event");
	spare_commit_a: assert property ($changed(spare_bit_upper_bytes) && !$past(srst)
		|-> $past(receive_multiframe_irq)) else $error("spare bytes changed without mark");
	spare_hold_a: assert property ($changed(spare_bit_upper_bytes) && !$past(srst)
		|=> $stable(spare_bit_upper_bytes)[*8]) else $error("spare bytes not held");

	cover property (reg_rd && reg_addr == OFS_FRAMING_HI);
	cover property (receive_multiframe_irq);
	cover property (counter_overflow[IDX_CRC]);
endmodule : pmc_perf_monitor_props

bind pmc_perf_monitor pmc_perf_monitor_props #(.SA_HOLD_CYCLES(SA_HOLD_CYCLES)) i_props (
	.clk(clk), .srst(srst), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .one_second_latch_enable(one_second_latch_enable),
	.test_pattern_start(test_pattern_start), .framing_bit_error(framing_bit_error),
	.crc_error(crc_error), .frame_loss_state(frame_loss_state),
	.alignment_change_pulse(alignment_change_pulse),
	.severely_errored_frame(severely_errored_frame),
	.receive_multiframe_irq(receive_multiframe_irq), .counter_overflow(counter_overflow),
	.spare_bit_upper_bytes(spare_bit_upper_bytes));

// ==== sim/pmc_host_model.sv ====
// Host model that reads the register port one byte at a time.
`timescale 1ns/1ps
module pmc_host_model
	import pmc_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Register port.
	output logic reg_rd,
	output logic [pmc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack
);
	initial begin
		reg_rd = 1'b0;
		reg_addr = 9'h000;
	end

	// One strobe cycle, then a bounded wait; the address is scrambled once released.
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (reg_ack === 1'b1) begin
				d = reg_rdata;
				ok = 1'b1;
			end else begin
				@(negedge clk);
			end
		end
		@(negedge clk);
	endtask : rd
endmodule : pmc_host_model

// ==== sim/testbench.sv ====
// Testbench of the performance monitor counters and spare-bit buffers.
`timescale 1ns/1ps
module testbench;
	import pmc_pkg::*;
	localparam int HOLD = 20;
	logic clk, srst, reg_rd, reg_ack, lat_en, tick, exz_en, start, fls, odd, mf;
	logic [ADDR_W-1:0] reg_addr;
	logic [7:0] reg_rdata, ev, ovf_en, ovf;
	logic [3:0] frame_num;
	logic [SA_LANES-1:0] sa;
	logic [23:0] upper;
	logic [39:0] pat;
	int miscompares, checks_done;

	// ----------------------------------------------------------------
	// Design, host and clock.
	// ----------------------------------------------------------------
	pmc_perf_monitor #(.SA_HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .srst(srst), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.one_second_latch_enable(lat_en), .one_second_tick(tick),
		.count_excess_zeros_enable(exz_en), .test_pattern_start(start),
		.overflow_irq_enables(ovf_en), .framing_bit_error(ev[0]), .crc_error(ev[1]),
		.bipolar_violation(ev[2]), .excess_zeros(ev[3]), .remote_block_error(ev[4]),
		.pattern_bit_error(ev[5]), .frame_loss_state(fls), .alignment_change_pulse(ev[6]),
		.severely_errored_frame(ev[7]), .odd_frame_strobe(odd), .frame_number(frame_num),
		.sa_bits(sa), .receive_multiframe_irq(mf), .counter_overflow(ovf),
		.spare_bit_upper_bytes(upper));
	pmc_host_model i_host (.clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("Mismatches %0d in %0d checks", miscompares, checks_done);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// A read that never answers ends the run as a mismatch.
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		i_host.rd(a, d, ok);
		if (!ok) begin
			miscompares++;
			conclude();
		end
		chk($sformatf("reg %h", a), {16'h0000, d}, {16'h0000, exp});
	endtask : rdc
	// Each mask bit stays high n cycles, one count per cycle.
	task automatic events(input logic [7:0] m, input int n);
		ev = m;
		repeat (n) @(negedge clk);
		ev = 8'h00;
		@(negedge clk);
	endtask : events
	task automatic frames(input logic [39:0] p);
		odd = 1'b1;
		for (int n = 0; n < 8; n++) begin
			frame_num = 4'(2 * n + 1);
			sa = {p[32 + n], p[24 + n], p[16 + n], p[8 + n], p[n]};
			@(negedge clk);
		end
		odd = 1'b0;
		mf = 1'b1;
		@(negedge clk);
		mf = 1'b0;
		@(negedge clk);
	endtask : frames

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		{srst, lat_en, tick, exz_en, start, fls, odd, mf} = 8'h80;
		{ev, ovf_en, frame_num, sa} = '0;
		miscompares = 0;
		checks_done = 0;
		repeat (10) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		// Everything reads zero after reset, an unmapped place too.
		for (int a = 'h4f; a <= 'h5c; a++) rdc(9'(a), 8'h00);
		events(8'h01, 5);
		rdc(OFS_FRAMING_LO, 8'h05);
		fork
			rdc(OFS_FRAMING_HI, 8'h00);
			events(8'h01, 1);
		join
		rdc(OFS_FRAMING_LO, 8'h01);
		rdc(OFS_FRAMING_HI, 8'h00);
		rdc(OFS_FRAMING_LO, 8'h00);
		events(8'h02, 1026);
		rdc(OFS_CRC_LO, 8'hff);
		rdc(OFS_CRC_HI, 8'h03);
		ovf_en = 8'h02;
		events(8'h02, 1025);
		rdc(OFS_CRC_LO, 8'h01);
		rdc(OFS_CRC_HI, 8'h00);
		events(8'h04, 3);
		events(8'h08, 2);
		rdc(OFS_LINE_LO, 8'h03);
		rdc(OFS_LINE_HI, 8'h00);
		exz_en = 1'b1;
		events(8'h08, 2);
		events(8'h0c, 1);
		rdc(OFS_LINE_LO, 8'h03);
		events(8'h10, 4);
		rdc(OFS_REMOTE_LO, 8'h04);
		rdc(OFS_REMOTE_LO, 8'h00);
		events(8'h10, 3);
		rdc(OFS_REMOTE_HI, 8'h00);
		rdc(OFS_REMOTE_LO, 8'h00);
		events(8'h20, 3);
		rdc(OFS_PATTERN_LO, 8'h00);
		rdc(OFS_PATTERN_LO, 8'h00);
		start = 1'b1;
		events(8'h20, 258);
		start = 1'b0;
		rdc(OFS_PATTERN_LO, 8'h02);
		rdc(OFS_PATTERN_HI, 8'h01);
		rdc(OFS_PATTERN_HI, 8'h01);
		rdc(OFS_PATTERN_LO, 8'h00);
		repeat (3) begin
			fls = 1'b1;
			@(negedge clk);
			fls = 1'b0;
			@(negedge clk);
		end
		events(8'h40, 2);
		events(8'h80, 1);
		rdc(OFS_ALARM, 8'h39);
		rdc(OFS_ALARM, 8'h00);
		// Sixteen frame losses wrap the count, the last one raising its overflow pulse.
		ovf_en = 8'h20;
		for (int i = 0; i < 16; i++) begin
			fls = 1'b1;
			@(negedge clk);
			fls = 1'b0;
			chk("loss overflow", {23'h0, ovf[IDX_FRAME_LOSS]}, {23'h0, i == 15});
			@(negedge clk);
		end
		rdc(OFS_ALARM, 8'h00);
		// Latched reads show the snapshot and leave the running count alone.
		lat_en = 1'b1;
		events(8'h01, 2);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
		events(8'h01, 3);
		rdc(OFS_FRAMING_LO, 8'h02);
		rdc(OFS_FRAMING_HI, 8'h00);
		rdc(OFS_FRAMING_LO, 8'h02);
		lat_en = 1'b0;
		rdc(OFS_FRAMING_LO, 8'h03);
		// Spare bytes are only read while frame alignment is reported as held.
		fls = 1'b0;
		pat = 40'he10f963ca5;
		frames(pat);
		rdc(OFS_SPARE4, pat[7:0]);
		rdc(OFS_SPARE5, pat[15:8]);
		chk("upper", upper, pat[39:16]);
		// A mark inside the hold window must not disturb the buffers.
		frames(~pat);
		rdc(OFS_SPARE4, pat[7:0]);
		repeat (HOLD) @(negedge clk);
		frames(~pat);
		rdc(OFS_SPARE5, ~pat[15:8]);
		chk("upper", upper, ~pat[39:16]);
		conclude();
	end
endmodule : testbench
